// [src/vwr_filter.sv]
// Persistence filter: output rises once input held longer than a delay
`timescale 1ns/10ps
`default_nettype none
module vwr_filter
	import vwr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Condition and delay
	input  wire logic             cond,
	input  wire logic [CNT_W-1:0] delay,
	// Filtered flag
	output var  logic             flag
);

	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
		logic             flag;
	} vwr_filt_t;

	vwr_filt_t s_q;
	vwr_filt_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (!cond)
		begin
			s_d.cnt = '0;
			s_d.flag = 1'b0;
		end
		else if (s_q.cnt > delay)
			s_d.flag = 1'b1;
		else
			s_d.cnt = s_q.cnt + 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flag = s_q.flag;

endmodule : vwr_filter
`default_nettype wire

// [src/vwr_hold.sv]
// Reset stretcher: holds a fault for a delay after the cause clears
`timescale 1ns/10ps
`default_nettype none
module vwr_hold
	import vwr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fault and delay
	input  wire logic             fault,
	input  wire logic [CNT_W-1:0] delay,
	// Held fault
	output var  logic             held
);

	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
		logic             held;
	} vwr_hold_t;

	vwr_hold_t s_q;
	vwr_hold_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (fault)
		begin
			// Restart on every fault cycle so the hold counts from return
			s_d.cnt = '0;
			s_d.held = 1'b1;
		end
		else if (s_q.held)
		begin
			if (s_q.cnt + 1'b1 >= delay)
				s_d.held = 1'b0;
			else
				s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign held = s_q.held;

endmodule : vwr_hold
`default_nettype wire

// [src/vwr_pkg.sv]
// Shared constants and types for the voltage window reset logic
package vwr_pkg;

	localparam int NCH = 4;
	localparam int NRST = 4;
	localparam int CNT_W = 24;
	localparam int THR_W = 12;

	// Clock rate and power-up hold time
	localparam int CLK_HZ = 40000000;
	localparam int PWRUP_HOLD_US = 1000;
	localparam int PWRUP_HOLD_CYC = (PWRUP_HOLD_US * (CLK_HZ / 1000000) < 1)
		? 1 : PWRUP_HOLD_US * (CLK_HZ / 1000000);

	// Output mode per channel
	typedef enum logic [1:0]
	{
		VWR_MODE_OVER   = 2'h0,
		VWR_MODE_UNDER  = 2'h1,
		VWR_MODE_WINDOW = 2'h2,
		VWR_MODE_OFF    = 2'h3
	} vwr_mode_t;

	// Start-up sequence
	typedef enum logic [1:0]
	{
		VWR_ST_CHECK  = 2'h0,
		VWR_ST_HOLD   = 2'h1,
		VWR_ST_ACTIVE = 2'h2,
		VWR_ST_ERROR  = 2'h3
	} vwr_state_t;

	// Register map
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK   = 4'h1;
	localparam logic [3:0] ADDR_FLAGS  = 4'h2;
	localparam logic [3:0] ADDR_STATE  = 4'h3;
	localparam logic [7:0] MASK_RESET  = 8'h00;

	// Status bit fields: under events low nibble, over events high nibble
	localparam int ST_UNDER_LSB = 0;
	localparam int ST_OVER_LSB  = 4;

endpackage : vwr_pkg

// [src/vwr_top.sv]
// Decision logic of a four-channel voltage window supervisor
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Under flag rises when below-threshold persists longer than the detect delay.
// - Over flag rises when above-threshold persists longer than the detect delay.
// - Per-channel outputs follow own channel as over, under or window.
// - Combined mode drives OR of all over flags and OR of under flags.
// - Channels keep being evaluated while any reset is asserted.
// - A fault reset is held at least the release hold delay.
// - All resets held for power-up time, released only once supply is good.
// - Hold delay restarts when the sense input returns inside the window.
// - Checksum checked before loading settings; mismatch blocks reset release.
// - Reset outputs are active low open-drain, driven low when asserted.
module vwr_top
	import vwr_pkg::*;
(
	// Clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  SYS_RST,
	// Comparator results, sampled on CLK_SYS
	input  wire logic [NCH-1:0]        SENSE_BELOW_UNDER,
	input  wire logic [NCH-1:0]        SENSE_ABOVE_OVER,
	// Static configuration
	input  wire logic [NCH*THR_W-1:0]  UNDER_THRESHOLD_SETTING,
	input  wire logic [NCH*THR_W-1:0]  OVER_THRESHOLD_SETTING,
	input  wire logic [NCH*2-1:0]      CHAN_MODE,
	input  wire logic                  COMBINED_MODE,
	input  wire logic [CNT_W-1:0]      DETECT_FILTER_DELAY,
	input  wire logic [CNT_W-1:0]      RELEASE_HOLD_DELAY,
	input  wire logic                  CHECKSUM_OK,
	input  wire logic                  CHECKSUM_DONE,
	input  wire logic                  SUPPLY_OK,
	// Register port
	input  wire logic [3:0]            REG_ADDR,
	input  wire logic [7:0]            REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output var  logic [7:0]            REG_RDATA,
	// Interrupt
	output var  logic                  IRQ,
	// Reset pins, open-drain: enable low drives low
	output var  logic [NRST-1:0]       CHANNEL_FAULT_OUTPUT_O,
	output var  logic [NRST-1:0]       CHANNEL_FAULT_OUTPUT_OE_N,
	// Visible flags
	output var  logic [NCH-1:0]        CHAN_UNDER_FLAG,
	output var  logic [NCH-1:0]        CHAN_OVER_FLAG,
	output var  logic [NCH*THR_W-1:0]  THRESHOLD_LOAD_UNDER,
	output var  logic [NCH*THR_W-1:0]  THRESHOLD_LOAD_OVER
);

	typedef struct packed
	{
		vwr_state_t           state;
		logic [CNT_W-1:0]     pwr_cnt;
		logic [NCH-1:0]       under_in;
		logic [NCH-1:0]       over_in;
		logic [7:0]           status;
		logic [7:0]           mask;
		logic [NCH-1:0]       under_prev;
		logic [NCH-1:0]       over_prev;
		logic [7:0]           rdata;
		logic                 irq;
		logic [NRST-1:0]      oe_n;
		logic [NCH-1:0]       uflag;
		logic [NCH-1:0]       oflag;
		logic [NCH*THR_W-1:0] thr_u;
		logic [NCH*THR_W-1:0] thr_o;
	} vwr_top_t;

	vwr_top_t s_q;
	vwr_top_t s_d;

	logic [NCH-1:0]  under_flag;
	logic [NCH-1:0]  over_flag;
	logic [NRST-1:0] fault_raw;
	logic [NRST-1:0] fault_held;
	logic [NRST-1:0] out_fault;
	logic [7:0]      events;

	// Per-channel filters and per-output hold timers
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_chan
			vwr_filter u_under
			(
				.clk   (CLK_SYS),
				.rst   (SYS_RST),
				.cond  (s_q.under_in[g]),
				.delay (DETECT_FILTER_DELAY),
				.flag  (under_flag[g])
			);
			vwr_filter u_over
			(
				.clk   (CLK_SYS),
				.rst   (SYS_RST),
				.cond  (s_q.over_in[g]),
				.delay (DETECT_FILTER_DELAY),
				.flag  (over_flag[g])
			);
			vwr_hold u_hold
			(
				.clk   (CLK_SYS),
				.rst   (SYS_RST),
				.fault (fault_raw[g]),
				.delay (RELEASE_HOLD_DELAY),
				.held  (fault_held[g])
			);
		end
	endgenerate

	// Output mapping
	always_comb
	begin
		fault_raw = '0;
		if (COMBINED_MODE)
		begin
			fault_raw[0] = |over_flag;
			fault_raw[1] = |under_flag;
		end
		else
		begin
			for (int i = 0; i < NRST; i++)
			begin
				case (vwr_mode_t'(CHAN_MODE[2*i +: 2]))
					VWR_MODE_OVER:   fault_raw[i] = over_flag[i];
					VWR_MODE_UNDER:  fault_raw[i] = under_flag[i];
					VWR_MODE_WINDOW: fault_raw[i] = over_flag[i] | under_flag[i];
					default:         fault_raw[i] = 1'b0;
				endcase
			end
		end
		// Hold restarts on every fault cycle, so release counts from return
		out_fault = fault_raw | fault_held;
	end

	assign events = {over_flag & ~s_q.over_prev,
		under_flag & ~s_q.under_prev};

	always_comb
	begin
		s_d = s_q;
		// Comparators registered once; filtering never stops in any state
		s_d.under_in = SENSE_BELOW_UNDER;
		s_d.over_in = SENSE_ABOVE_OVER;
		s_d.under_prev = under_flag;
		s_d.over_prev = over_flag;
		s_d.uflag = under_flag;
		s_d.oflag = over_flag;
		s_d.rdata = 8'h00;

		case (s_q.state)
			VWR_ST_CHECK:
			begin
				s_d.oe_n = '0;
				if (CHECKSUM_DONE)
				begin
					if (CHECKSUM_OK)
					begin
						// Thresholds latched only after integrity passes
						s_d.thr_u = UNDER_THRESHOLD_SETTING;
						s_d.thr_o = OVER_THRESHOLD_SETTING;
						s_d.state = VWR_ST_HOLD;
					end
					else
						s_d.state = VWR_ST_ERROR;
				end
			end
			VWR_ST_HOLD:
			begin
				s_d.oe_n = '0;
				if (s_q.pwr_cnt < CNT_W'(PWRUP_HOLD_CYC - 1))
					s_d.pwr_cnt = s_q.pwr_cnt + 1'b1;
				else if (SUPPLY_OK)
					s_d.state = VWR_ST_ACTIVE;
			end
			VWR_ST_ACTIVE:
			begin
				// Asserted reset means drive low: enable low
				s_d.oe_n = ~out_fault;
				if (!SUPPLY_OK)
				begin
					s_d.pwr_cnt = '0;
					s_d.state = VWR_ST_HOLD;
				end
			end
			default:
				// Stuck here until reset: a bad checksum never releases
				s_d.oe_n = '0;
		endcase

		// Reads of ADDR_STATUS clear status; new events win over the clear
		if (REG_RD)
		begin
			if (REG_ADDR == ADDR_STATUS)
			begin
				s_d.rdata = s_q.status;
				s_d.status = 8'h00;
			end
			else if (REG_ADDR == ADDR_MASK)
				s_d.rdata = s_q.mask;
			else if (REG_ADDR == ADDR_FLAGS)
				s_d.rdata = {over_flag, under_flag};
			else if (REG_ADDR == ADDR_STATE)
				s_d.rdata = {6'h00, s_q.state};
			else
				s_d.rdata = 8'h00;
		end
		if (REG_WR && REG_ADDR == ADDR_MASK)
			s_d.mask = REG_WDATA;
		s_d.status = s_d.status | events;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s_q <= '0;
			s_q.state <= VWR_ST_CHECK;
			s_q.mask <= MASK_RESET;
		end
		else
			s_q <= s_d;
	end

	assign REG_RDATA = s_q.rdata;
	assign IRQ = s_q.irq;
	assign CHANNEL_FAULT_OUTPUT_O = '0;
	assign CHANNEL_FAULT_OUTPUT_OE_N = s_q.oe_n;
	assign CHAN_UNDER_FLAG = s_q.uflag;
	assign CHAN_OVER_FLAG = s_q.oflag;
	assign THRESHOLD_LOAD_UNDER = s_q.thr_u;
	assign THRESHOLD_LOAD_OVER = s_q.thr_o;

endmodule : vwr_top
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the voltage window reset logic
`timescale 1ns/10ps
`default_nettype none
module testbench
	import vwr_pkg::*;
;
	localparam logic [7:0] MODES = 8'hE4;
	localparam logic [47:0] THR_U = 48'h0123456789AB;
	localparam logic [47:0] THR_O = 48'hBA9876543210;
	logic [47:0]	thu, tho;
	logic	clk = 1'b0, rst = 1'b1, comb = 1'b0, wr = 1'b0, rd = 1'b0;
	logic	ok = 1'b0, done = 1'b0, sup = 1'b0, irq;
	logic [3:0]	bl = 4'h0, ab = 4'h0, addr = 4'h0, ufl, ofl, od, oe_n, lvl;
	logic [7:0]	wd = 8'h00, rdata;
	int	num_errors = 0, total_checks = 0, seed = 57;
	always #12.5 clk = ~clk;
	vwr_top u_dut (.CLK_SYS(clk), .SYS_RST(rst), .SENSE_BELOW_UNDER(bl),
		.SENSE_ABOVE_OVER(ab), .UNDER_THRESHOLD_SETTING(THR_U),
		.OVER_THRESHOLD_SETTING(THR_O), .CHAN_MODE(MODES),
		.COMBINED_MODE(comb), .DETECT_FILTER_DELAY(24'h4),
		.RELEASE_HOLD_DELAY(24'h6), .CHECKSUM_OK(ok), .CHECKSUM_DONE(done),
		.SUPPLY_OK(sup), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq),
		.CHANNEL_FAULT_OUTPUT_O(od), .CHANNEL_FAULT_OUTPUT_OE_N(oe_n),
		.CHAN_UNDER_FLAG(ufl), .CHAN_OVER_FLAG(ofl),
		.THRESHOLD_LOAD_UNDER(thu), .THRESHOLD_LOAD_OVER(tho));
	vwr_host u_host (.drv_o(od), .drv_oe_n(oe_n), .lvl(lvl));
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_thr(input logic [95:0] got, input logic [95:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %0t thresholds got %h expected %h", $time, got, exp);
		end
	endtask : chk_thr
	// Register access: write or read, read data checked in its one cycle
	task automatic rg(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 if (!w) chk(rdata, d);
	endtask : rg
	function automatic logic [3:0] lv(input logic [3:0] b, input logic [3:0] a);
		logic [3:0] f;
		for (int i = 0; i < 4; i++)
			case (MODES[2*i+:2])
				2'h0: f[i] = a[i];
				2'h1: f[i] = b[i];
				2'h2: f[i] = a[i] | b[i];
				default: f[i] = 1'b0;
			endcase
		if (comb)
			f = {2'h0, |b, |a};
		return ~f;
	endfunction : lv
	task automatic boot(input logic good);
		@(posedge clk);
		rst <= 1'b1;
		ok <= good;
		done <= 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		done <= 1'b1;
	endtask : boot
	// Comparator fault held, then cleared; pins must outlast it
	task automatic flt(input logic [3:0] b, input logic [3:0] a0);
		logic [3:0] a;
		a = a0 & ~b;
		@(posedge clk);
		bl <= b;
		ab <= a;
		repeat (12) @(posedge clk);
		#1 chk(ufl, b);
		chk(ofl, a);
		chk(lvl, lv(b, a));
		rg(0, ADDR_FLAGS, {a, b});
		@(posedge clk);
		bl <= 4'h0;
		ab <= 4'h0;
		// Last cycle before the six-cycle hold may end
		repeat (8) @(posedge clk);
		#1 chk(lvl, lv(b, a));
		repeat (8) @(posedge clk);
		#1 chk(lvl, 4'hF);
	endtask : flt
	initial
	begin
		repeat (60000) @(posedge clk);
		num_errors++;
		end_of_test;
	end
	initial
	begin
		boot(1'b0);
		rg(0, ADDR_STATE, 8'h03);
		chk(lvl, 4'h0);
		chk_thr({thu, tho}, 96'h0);
		boot(1'b1);
		repeat (PWRUP_HOLD_CYC + 100) @(posedge clk);
		#1 chk(lvl, 4'h0);
		chk_thr({thu, tho}, {THR_U, THR_O});
		@(posedge clk);
		sup <= 1'b1;
		rg(0, ADDR_STATE, 8'h02);
		chk(lvl, 4'hF);
		rg(0, ADDR_MASK, MASK_RESET);
		rg(1, ADDR_MASK, 8'h01);
		rg(0, ADDR_MASK, 8'h01);
		rg(1, ADDR_STATUS, 8'hFF);
		rg(0, ADDR_STATUS, 8'h00);
		rg(0, 4'hF, 8'h00);
		flt(4'h1, 4'h0);
		chk(irq, 1'b1);
		rg(0, ADDR_STATUS, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'b0);
		flt(4'h0, 4'h2);
		chk(irq, 1'b0);
		rg(0, ADDR_STATUS, 8'h20);
		flt(4'h1, 4'h4);
		repeat (8) flt(4'($random(seed)), 4'($random(seed)));
		@(posedge clk);
		comb <= 1'b1;
		flt(4'h0, 4'h8);
		repeat (6) flt(4'($random(seed)), 4'($random(seed)));
		@(posedge clk);
		sup <= 1'b0;
		rg(0, ADDR_STATE, 8'h01);
		chk(lvl, 4'h0);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire

// [verif/vwr_host.sv]
// Host reset inputs behind the open-drain reset pins
`timescale 1ns/10ps
`default_nettype none
module vwr_host
(
	// Pins from the supervisor
	input	wire logic [3:0]	drv_o,
	input	wire logic [3:0]	drv_oe_n,
	// Levels seen by the host
	output	var logic [3:0]	lvl
);
	// External pull-up gives the high level once released
	always_comb
		for (int i = 0; i < 4; i++)
			lvl[i] = drv_oe_n[i] ? 1'b1 : drv_o[i];
endmodule : vwr_host
`default_nettype wire

// [verif/vwr_properties.sv]
// Port checker for the voltage window reset logic
`timescale 1ns/10ps
`default_nettype none
module vwr_chk
	import vwr_pkg::*;
(
	// Watched top ports
	input	wire logic	CLK_SYS,
	input	wire logic	SYS_RST,
	input	wire logic [3:0]	SENSE_BELOW_UNDER,
	input	wire logic [3:0]	SENSE_ABOVE_OVER,
	input	wire logic [7:0]	CHAN_MODE,
	input	wire logic	COMBINED_MODE,
	input	wire logic	CHECKSUM_OK,
	input	wire logic	CHECKSUM_DONE,
	input	wire logic	REG_RD,
	input	wire logic [7:0]	REG_RDATA,
	input	wire logic	IRQ,
	input	wire logic [3:0]	CHANNEL_FAULT_OUTPUT_O,
	input	wire logic [3:0]	CHANNEL_FAULT_OUTPUT_OE_N,
	input	wire logic [3:0]	CHAN_UNDER_FLAG,
	input	wire logic [3:0]	CHAN_OVER_FLAG
);
	logic [3:0]	fv;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Fault each pin must show, from the visible flags
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			case (CHAN_MODE[2*i+:2])
				2'h0: fv[i] = CHAN_OVER_FLAG[i];
				2'h1: fv[i] = CHAN_UNDER_FLAG[i];
				2'h2: fv[i] = CHAN_OVER_FLAG[i] | CHAN_UNDER_FLAG[i];
				default: fv[i] = 1'b0;
			endcase
		if (COMBINED_MODE)
			fv = {2'h0, |CHAN_UNDER_FLAG, |CHAN_OVER_FLAG};
	end
	chk_od_level: assert property (CHANNEL_FAULT_OUTPUT_O == 4'h0)
		else $error("pin drives high");
	chk_start_low: assert property (
		!CHECKSUM_DONE |-> CHANNEL_FAULT_OUTPUT_OE_N == 4'h0)
		else $error("early release");
	chk_sum_block: assert property (
		CHECKSUM_DONE && !CHECKSUM_OK |-> CHANNEL_FAULT_OUTPUT_OE_N == 4'h0)
		else $error("bad sum release");
	chk_under_cause: assert property (
		(CHAN_UNDER_FLAG & ~$past(CHAN_UNDER_FLAG)
		& ~$past(SENSE_BELOW_UNDER, 4)) == 4'h0) else $error("under");
	chk_over_cause: assert property (
		(CHAN_OVER_FLAG & ~$past(CHAN_OVER_FLAG)
		& ~$past(SENSE_ABOVE_OVER, 4)) == 4'h0) else $error("over");
	chk_under_detect: assert property (
		SENSE_BELOW_UNDER[0] [*8] |-> ##[0:6] CHAN_UNDER_FLAG[0])
		else $error("under late");
	chk_over_detect: assert property (
		SENSE_ABOVE_OVER[1] [*8] |-> ##[0:6] CHAN_OVER_FLAG[1])
		else $error("over late");
	chk_mode_map: assert property (
		(CHANNEL_FAULT_OUTPUT_OE_N & $past(fv)) == 4'h0)
		else $error("pin map");
	// With a hold of six cycles the pin may rise no sooner than this
	chk_hold_time: assert property (
		$rose(CHANNEL_FAULT_OUTPUT_OE_N[0]) |-> !$past(fv[0], 6))
		else $error("short hold");
	chk_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("stray read data");
	cover property ($fell(CHANNEL_FAULT_OUTPUT_OE_N[2]));
	cover property ($rose(IRQ));
	cover property (COMBINED_MODE && !CHANNEL_FAULT_OUTPUT_OE_N[1]);
endmodule : vwr_chk
bind vwr_top vwr_chk u_chk
(
	.CLK_SYS                   (CLK_SYS),
	.SYS_RST                   (SYS_RST),
	.SENSE_BELOW_UNDER         (SENSE_BELOW_UNDER),
	.SENSE_ABOVE_OVER          (SENSE_ABOVE_OVER),
	.CHAN_MODE                 (CHAN_MODE),
	.COMBINED_MODE             (COMBINED_MODE),
	.CHECKSUM_OK               (CHECKSUM_OK),
	.CHECKSUM_DONE             (CHECKSUM_DONE),
	.REG_RD                    (REG_RD),
	.REG_RDATA                 (REG_RDATA),
	.IRQ                       (IRQ),
	.CHANNEL_FAULT_OUTPUT_O    (CHANNEL_FAULT_OUTPUT_O),
	.CHANNEL_FAULT_OUTPUT_OE_N (CHANNEL_FAULT_OUTPUT_OE_N),
	.CHAN_UNDER_FLAG           (CHAN_UNDER_FLAG),
	.CHAN_OVER_FLAG            (CHAN_OVER_FLAG)
);
`default_nettype wire
